// ==== hw/tlo_defs.svh ====
`ifndef TLO_DEFS_SVH
`define TLO_DEFS_SVH
// ==========================================================
// register indices (byte address = index * 4)
`define TLO_IDX_R1_LIMIT 8'h6A
`define TLO_IDX_LC_LIMIT 8'h6B
`define TLO_IDX_R2_LIMIT 8'h6C
`define TLO_IDX_HYST_R1L 8'h6D
`define TLO_IDX_HYST_R2 8'h6E
`define TLO_IDX_TEST_EN 8'h6F
`define TLO_IDX_R1_OFFSET 8'h70
`define TLO_IDX_LC_OFFSET 8'h71
`define TLO_IDX_R2_OFFSET 8'h72
`define TLO_IDX_IRQ_STATUS 8'h78
`define TLO_IDX_IRQ_MASK 8'h79
// ==========================================================
// reset values
`define TLO_RST_LIMIT 8'h64
`define TLO_RST_HYST_R1L 8'h44
`define TLO_RST_HYST_R2 8'h40
`define TLO_RST_TEST_EN 8'h00
`define TLO_RST_OFFSET 8'h00
`define TLO_RST_IRQ 8'h00
// ==========================================================
// field positions and special codes
`define TLO_HYST_HI_MSB 7
`define TLO_HYST_HI_LSB 4
`define TLO_HYST_LO_MSB 3
`define TLO_HYST_LO_LSB 0
`define TLO_TEST_EN_BIT 0
`define TLO_LIMIT_OFF 8'h80
`define TLO_FULL_DUTY 8'hFF
`define TLO_NUM_CH 3
// status bit of the pin event (channel entries use bits 2:0)
`define TLO_IRQ_PIN_BIT 3
`endif

// ==== hw/tlo_pkg.sv ====
package tlo_pkg;
  // temperature in quarter degrees, unsigned
  typedef logic [9:0] tlo_temp_t;
  // wide signed value for threshold arithmetic
  typedef logic signed [11:0] tlo_wide_t;
  // per-channel fail-safe state
  typedef enum logic {TLO_OT_IDLE, TLO_OT_FORCED} tlo_ot_e;
endpackage

// ==== hw/tlo_regs.sv ====
// Implementation choice: the Wishbone slave port.
`timescale 1ns/10ps
`include "tlo_defs.svh"
// How it works
// RULE1 - three 8-bit overtemperature limits, remote1, local, remote2, reset to 0x64
// RULE2 - any channel above its limit forces every PWM output to full duty
// RULE3 - a limit of 0x80 disables that channel's full-duty comparison
// RULE4 - full duty holds until temperature falls below limit minus hysteresis
// RULE5 - pin driven low when above limit by 0.25 degrees and configured output
// RULE6 - register 0x6D holds local hysteresis low nibble, remote1 high, resets 0x44
// RULE7 - register 0x6E holds remote2 hysteresis in upper nibble, resets 0x40
// RULE8 - below fan start, fan stays at minimum until start minus hysteresis
// RULE9 - one hysteresis per channel serves fan start and overtemperature release
// RULE10 - software should program hysteresis of at least 4 degrees
// RULE11 - lock bit set makes all these registers read-only, writes ignored
// RULE12 - bit 0 of 0x6F enters logic-tree test mode; register resets to 0x00
// RULE13 - software must not write bits 7 to 1 of the test register
// RULE14 - signed offset in 0x70, half degree per bit, added to remote1 reading
// RULE15 - signed offset in 0x71, half degree per bit, added to local reading
// RULE16 - signed offset in 0x72, half degree per bit, added to remote2 reading
// RULE17 - above fan start the fan runs at minimum and ramps with temperature
// RULE18 - duty code 0xFF gives full duty, used by the fail-safe
// RULE19 - all comparisons use the offset-corrected temperature
module tlo_regs
  import tlo_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic config_lock,
  input wire logic overtemp_pin_out_cfg,
  input wire tlo_temp_t raw_remote1_temp,
  input wire tlo_temp_t raw_local_temp,
  input wire tlo_temp_t raw_remote2_temp,
  input wire logic [7:0] remote1_fan_start_temp,
  input wire logic [7:0] local_fan_start_temp,
  input wire logic [7:0] remote2_fan_start_temp,
  input wire logic [7:0] auto_duty_pwm1,
  input wire logic [7:0] auto_duty_pwm2,
  input wire logic [7:0] auto_duty_pwm3,
  input wire logic overtemp_pin_i,
  output logic overtemp_pin_o,
  output logic overtemp_pin_oe,
  output logic [7:0] pwm1_duty,
  output logic [7:0] pwm2_duty,
  output logic [7:0] pwm3_duty,
  output logic [2:0] fan_run,
  output logic [2:0] failsafe_active,
  output tlo_temp_t remote1_corr_temp,
  output tlo_temp_t local_corr_temp,
  output tlo_temp_t remote2_corr_temp,
  output logic logic_tree_test_en,
  output logic irq
);
  // ==========================================================
  // register state
  logic [7:0] limit [3];
  logic [7:0] offset [3];
  logic [7:0] hyst_r1l;
  logic [7:0] hyst_r2;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] next_limit [3];
  logic [7:0] next_offset [3];
  logic [7:0] next_hyst_r1l;
  logic [7:0] next_hyst_r2;
  logic next_test_en;
  logic [7:0] next_irq_status;
  logic [7:0] next_irq_mask;
  logic [31:0] next_dat;
  logic next_ack;
  logic [7:0] idx;
  logic req;
  logic wr;
  logic wr_cfg;
  tlo_temp_t raw [3];
  tlo_temp_t corr [3];
  logic [7:0] fan_start [3];
  logic [3:0] hyst [3];
  tlo_ot_e ot_state [3];
  logic [2:0] ot_enter;
  logic [2:0] pin_hit;
  logic next_pin_oe;
  logic [7:0] next_pwm [3];
  logic [7:0] auto_duty [3];
  logic next_irq;
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign wr_cfg = wr & ~config_lock; // RULE11
  assign raw[0] = raw_remote1_temp;
  assign raw[1] = raw_local_temp;
  assign raw[2] = raw_remote2_temp;
  assign fan_start[0] = remote1_fan_start_temp;
  assign fan_start[1] = local_fan_start_temp;
  assign fan_start[2] = remote2_fan_start_temp;
  assign auto_duty[0] = auto_duty_pwm1;
  assign auto_duty[1] = auto_duty_pwm2;
  assign auto_duty[2] = auto_duty_pwm3;
  // hysteresis field per channel, shared by both comparators
  assign hyst[0] = hyst_r1l[`TLO_HYST_HI_MSB:`TLO_HYST_HI_LSB]; // RULE6 RULE9
  assign hyst[1] = hyst_r1l[`TLO_HYST_LO_MSB:`TLO_HYST_LO_LSB]; // RULE6 RULE9
  assign hyst[2] = hyst_r2[`TLO_HYST_HI_MSB:`TLO_HYST_HI_LSB]; // RULE7 RULE9
  assign corr[0] = remote1_corr_temp;
  assign corr[1] = local_corr_temp;
  assign corr[2] = remote2_corr_temp;
  // ==========================================================
  // bus slave and register writes
  always_comb begin
    next_hyst_r1l = hyst_r1l;
    next_hyst_r2 = hyst_r2;
    next_test_en = logic_tree_test_en;
    next_irq_mask = irq_mask;
    next_ack = req;
    next_dat = 32'h00000000;
    for (int c = 0; c < `TLO_NUM_CH; c++) begin
      next_limit[c] = limit[c];
      next_offset[c] = offset[c];
      if (wr_cfg && idx == `TLO_IDX_R1_LIMIT + 8'(c)) begin
        next_limit[c] = wb_dat_i[7:0]; // RULE1
      end
      if (wr_cfg && idx == `TLO_IDX_R1_OFFSET + 8'(c)) begin
        next_offset[c] = wb_dat_i[7:0]; // RULE14 RULE15 RULE16
      end
    end
    if (wr_cfg && idx == `TLO_IDX_HYST_R1L) begin
      next_hyst_r1l = wb_dat_i[7:0]; // RULE6
    end
    if (wr_cfg && idx == `TLO_IDX_HYST_R2) begin
      next_hyst_r2 = wb_dat_i[7:0]; // RULE7
    end
    if (wr_cfg && idx == `TLO_IDX_TEST_EN) begin
      next_test_en = wb_dat_i[`TLO_TEST_EN_BIT]; // RULE12
    end
    if (wr && idx == `TLO_IDX_IRQ_MASK) begin
      next_irq_mask = wb_dat_i[7:0];
    end
    if (req && !wb_we_i) begin
      unique case (idx)
        `TLO_IDX_R1_LIMIT: next_dat[7:0] = limit[0];
        `TLO_IDX_LC_LIMIT: next_dat[7:0] = limit[1];
        `TLO_IDX_R2_LIMIT: next_dat[7:0] = limit[2];
        `TLO_IDX_HYST_R1L: next_dat[7:0] = hyst_r1l;
        `TLO_IDX_HYST_R2: next_dat[7:0] = hyst_r2;
        `TLO_IDX_TEST_EN: next_dat[7:0] = {7'h00, logic_tree_test_en};
        `TLO_IDX_R1_OFFSET: next_dat[7:0] = offset[0];
        `TLO_IDX_LC_OFFSET: next_dat[7:0] = offset[1];
        `TLO_IDX_R2_OFFSET: next_dat[7:0] = offset[2];
        `TLO_IDX_IRQ_STATUS: next_dat[7:0] = irq_status;
        `TLO_IDX_IRQ_MASK: next_dat[7:0] = irq_mask;
        default: next_dat = 32'h00000000; // unmapped reads as zero
      endcase
    end
  end
  // register the bus side
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < `TLO_NUM_CH; c++) begin
        limit[c] <= `TLO_RST_LIMIT; // RULE1
        offset[c] <= `TLO_RST_OFFSET;
      end
      hyst_r1l <= `TLO_RST_HYST_R1L; // RULE6
      hyst_r2 <= `TLO_RST_HYST_R2; // RULE7
      logic_tree_test_en <= 1'b0; // RULE12
      irq_mask <= `TLO_RST_IRQ;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      limit <= next_limit;
      offset <= next_offset;
      hyst_r1l <= next_hyst_r1l;
      hyst_r2 <= next_hyst_r2;
      logic_tree_test_en <= next_test_en;
      irq_mask <= next_irq_mask;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ==========================================================
  // per-channel correction and comparison
  for (genvar ch = 0; ch < `TLO_NUM_CH; ch++) begin : g_ch
    tlo_wide_t sum;
    tlo_wide_t lim_q;
    tlo_wide_t rel_q;
    tlo_wide_t start_q;
    tlo_wide_t start_rel_q;
    tlo_temp_t next_corr;
    tlo_ot_e next_ot;
    logic next_fan;
    logic lim_on;
    // offset is half degrees, so two quarter-degree steps per bit
    assign sum = $signed({2'b00, raw[ch]}) + $signed({{3{offset[ch][7]}}, offset[ch], 1'b0});
    assign lim_q = $signed({2'b00, limit[ch], 2'b00});
    assign rel_q = lim_q - $signed({6'h00, hyst[ch], 2'b00}); // RULE4 RULE9
    assign start_q = $signed({2'b00, fan_start[ch], 2'b00});
    assign start_rel_q = start_q - $signed({6'h00, hyst[ch], 2'b00}); // RULE8 RULE9
    assign lim_on = limit[ch] != `TLO_LIMIT_OFF; // RULE3
    // next corrected reading, state and fan run flag
    always_comb begin
      next_corr = sum[9:0]; // RULE14 RULE15 RULE16
      if (sum < 12'sh000) begin
        next_corr = 10'h000;
      end else if (sum > 12'sh3FF) begin
        next_corr = 10'h3FF;
      end
      next_ot = ot_state[ch];
      unique case (ot_state[ch])
        TLO_OT_IDLE: begin
          if (lim_on && $signed({2'b00, corr[ch]}) > lim_q) begin
            next_ot = TLO_OT_FORCED; // RULE2 RULE19
          end
        end
        TLO_OT_FORCED: begin
          if (!lim_on || $signed({2'b00, corr[ch]}) < rel_q) begin
            next_ot = TLO_OT_IDLE; // RULE3 RULE4
          end
        end
      endcase
      next_fan = fan_run[ch];
      if ($signed({2'b00, corr[ch]}) > start_q) begin
        next_fan = 1'b1; // RULE17 RULE19
      end else if ($signed({2'b00, corr[ch]}) <= start_rel_q) begin
        next_fan = 1'b0; // RULE8
      end
    end
    assign ot_enter[ch] = (ot_state[ch] == TLO_OT_IDLE) && (next_ot == TLO_OT_FORCED);
    // exceeding by a quarter degree or more may pull the pin low
    assign pin_hit[ch] = lim_on && $signed({2'b00, corr[ch]}) > lim_q; // RULE5
    // register the channel state
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ot_state[ch] <= TLO_OT_IDLE;
        fan_run[ch] <= 1'b0;
        failsafe_active[ch] <= 1'b0;
      end else begin
        ot_state[ch] <= next_ot;
        fan_run[ch] <= next_fan;
        failsafe_active[ch] <= next_ot == TLO_OT_FORCED;
      end
    end
    if (ch == 0) begin : g_c0
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) remote1_corr_temp <= 10'h000;
        else remote1_corr_temp <= next_corr;
      end
    end else if (ch == 1) begin : g_c1
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) local_corr_temp <= 10'h000;
        else local_corr_temp <= next_corr;
      end
    end else begin : g_c2
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) remote2_corr_temp <= 10'h000;
        else remote2_corr_temp <= next_corr;
      end
    end
    // assertions for this channel
    property p_enter;
      @(posedge ref_clk) disable iff (!rst_n)
      lim_on && $signed({2'b00, corr[ch]}) > lim_q |=> ot_state[ch] == TLO_OT_FORCED;
    endproperty
    a_enter: assert property (p_enter) else $error("limit exceeded but no force"); // RULE2
    property p_disabled;
      @(posedge ref_clk) disable iff (!rst_n)
      limit[ch] == `TLO_LIMIT_OFF |=> ot_state[ch] == TLO_OT_IDLE;
    endproperty
    a_disabled: assert property (p_disabled) else $error("disabled limit forced"); // RULE3
    property p_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      ot_state[ch] == TLO_OT_FORCED && lim_on && $signed({2'b00, corr[ch]}) >= rel_q
        |=> ot_state[ch] == TLO_OT_FORCED;
    endproperty
    a_hold: assert property (p_hold) else $error("force released above hysteresis"); // RULE4
    property p_fan_hold;
      @(posedge ref_clk) disable iff (!rst_n)
      fan_run[ch] && $signed({2'b00, corr[ch]}) > start_rel_q |=> fan_run[ch];
    endproperty
    a_fan_hold: assert property (p_fan_hold) else $error("fan stopped early"); // RULE8
    property p_fan_start;
      @(posedge ref_clk) disable iff (!rst_n)
      $signed({2'b00, corr[ch]}) > start_q |=> fan_run[ch];
    endproperty
    a_fan_start: assert property (p_fan_start) else $error("fan not started"); // RULE17
  end
  // ==========================================================
  // pwm override, pin drive and interrupts
  always_comb begin
    for (int c = 0; c < `TLO_NUM_CH; c++) begin
      next_pwm[c] = (|failsafe_active) ? `TLO_FULL_DUTY : auto_duty[c]; // RULE2 RULE18
    end
    next_pin_oe = overtemp_pin_out_cfg & (|pin_hit); // RULE5
    next_irq_status = irq_status;
    if (req && !wb_we_i && idx == `TLO_IDX_IRQ_STATUS) begin
      next_irq_status = `TLO_RST_IRQ; // read clears
    end
    // new events win over the clear
    next_irq_status[2:0] = next_irq_status[2:0] | ot_enter;
    if (!overtemp_pin_oe && !overtemp_pin_i) begin
      next_irq_status[`TLO_IRQ_PIN_BIT] = 1'b1;
    end
    next_irq = |(next_irq_status & next_irq_mask);
  end
  // register pwm, pin and interrupt state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm1_duty <= 8'h00;
      pwm2_duty <= 8'h00;
      pwm3_duty <= 8'h00;
      overtemp_pin_oe <= 1'b0;
      overtemp_pin_o <= 1'b0;
      irq_status <= `TLO_RST_IRQ;
      irq <= 1'b0;
    end else begin
      pwm1_duty <= next_pwm[0];
      pwm2_duty <= next_pwm[1];
      pwm3_duty <= next_pwm[2];
      overtemp_pin_oe <= next_pin_oe;
      overtemp_pin_o <= 1'b0; // pin only ever pulled low
      irq_status <= next_irq_status;
      irq <= next_irq;
    end
  end

  // ==========================================================
  // block-level assertions
  property p_full_duty;
    @(posedge ref_clk) disable iff (!rst_n)
    |failsafe_active |=> pwm1_duty == 8'hFF && pwm2_duty == 8'hFF && pwm3_duty == 8'hFF;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("pwm not full in fail-safe"); // RULE18
  property p_lock;
    @(posedge ref_clk) disable iff (!rst_n)
    config_lock && req && wb_we_i |=> $stable(limit[0]) && $stable(hyst_r1l) && $stable(offset[2]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked register changed"); // RULE11
  property p_test_en;
    @(posedge ref_clk) disable iff (!rst_n)
    wr_cfg && idx == `TLO_IDX_TEST_EN |=> logic_tree_test_en == $past(wb_dat_i[0]);
  endproperty
  a_test_en: assert property (p_test_en) else $error("test enable not written"); // RULE12
  property p_offset_zero;
    @(posedge ref_clk) disable iff (!rst_n)
    offset[1] == 8'h00 |=> local_corr_temp == $past(raw_local_temp);
  endproperty
  a_offset_zero: assert property (p_offset_zero) else $error("local correction wrong"); // RULE15
  property p_pin;
    @(posedge ref_clk) disable iff (!rst_n)
    overtemp_pin_out_cfg && (|pin_hit) |=> overtemp_pin_oe && !overtemp_pin_o;
  endproperty
  a_pin: assert property (p_pin) else $error("pin not driven low"); // RULE5
  property p_irq;
    @(posedge ref_clk) disable iff (!rst_n)
    |(irq_status & irq_mask) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");
  c_force: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(|failsafe_active));
  c_release: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(|failsafe_active));
  c_locked_wr: cover property (@(posedge ref_clk) disable iff (!rst_n) config_lock && wr);
endmodule // tlo_regs

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top
  import tlo_pkg::*;
;
  // ==========================================================
  // bench signals
  logic ref_clk, rst_n, cyc, stb, we, ack, lock, out_cfg, ext_low, pin_o, pin_oe, pin_i;
  logic test_en, irq;
  logic [9:0] adr;
  logic [31:0] wdat, rdat;
  logic [3:0] sel;
  tlo_temp_t raw_r1, raw_lc, raw_r2, c_r1, c_lc, c_r2;
  logic [7:0] st_r1, st_lc, st_r2, ad1, ad2, ad3, pwm1, pwm2, pwm3, q;
  logic [2:0] fan_run, fsafe;
  int bad_count, n_compared;
  logic [7:0] ri [9] = '{8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F, 8'h70, 8'h71, 8'h72};
  logic [7:0] rv [9] = '{8'h64, 8'h64, 8'h64, 8'h44, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
  // open-drain pin: low if the block or the outside pulls it, else pulled up
  assign pin_i = (pin_oe | ext_low) ? 1'b0 : 1'b1;

  tlo_regs i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
    .wb_ack_o(ack), .config_lock(lock), .overtemp_pin_out_cfg(out_cfg),
    .raw_remote1_temp(raw_r1), .raw_local_temp(raw_lc), .raw_remote2_temp(raw_r2),
    .remote1_fan_start_temp(st_r1), .local_fan_start_temp(st_lc),
    .remote2_fan_start_temp(st_r2), .auto_duty_pwm1(ad1), .auto_duty_pwm2(ad2),
    .auto_duty_pwm3(ad3), .overtemp_pin_i(pin_i), .overtemp_pin_o(pin_o),
    .overtemp_pin_oe(pin_oe), .pwm1_duty(pwm1), .pwm2_duty(pwm2), .pwm3_duty(pwm3),
    .fan_run(fan_run), .failsafe_active(fsafe), .remote1_corr_temp(c_r1),
    .local_corr_temp(c_lc), .remote2_corr_temp(c_r2), .logic_tree_test_en(test_en),
    .irq(irq));

  // ==========================================================
  // clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end

  // ==========================================================
  // shared tasks
  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    sel <= s;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("wb_ack", 1, ack);
      stop_test();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'hF);
  endtask
  task automatic rd(input string nm, input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, 4'hF);
    chk(nm, e, q);
  endtask
  task automatic set_lc(input tlo_temp_t t);
    @(posedge ref_clk);
    raw_lc <= t;
    tick(4);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    for (int i = 0; i < 9; i++) rd("reset_value", ri[i], rv[i]);
    rd("status_reset", 8'h78, 8'h00);
    rd("unmapped_read", 8'h50, 8'h00);
    chk("reset_outputs", {3'b000, 1'b0, 1'b0}, {fsafe, test_en, irq});
    chk("pwm_auto", {8'h30, 8'h31, 8'h32}, {pwm1, pwm2, pwm3});
  endtask
  task automatic t_regs();
    for (int i = 0; i < 9; i++) if (i != 5) wr(ri[i], 8'hA4 + 8'(i));
    wr(8'h6F, 8'h01);
    for (int i = 0; i < 9; i++) rd("rw_back", ri[i], (i == 5) ? 8'h01 : 8'hA4 + 8'(i));
    tick(1);
    chk("test_mode_on", 1, test_en);
    wr(8'h6F, 8'h00);
    tick(2);
    chk("test_mode_off", 0, test_en);
    do_reset();
    rd("limit_after_reset", 8'h6A, 8'h64);
    wb(1'b1, 8'h6A, 8'h11, 4'h0);
    rd("sel_off_write", 8'h6A, 8'h64);
    wr(8'h50, 8'h5A);
    rd("unmapped_write", 8'h50, 8'h00);
  endtask
  task automatic t_fan();
    tlo_temp_t t [4] = '{10'd240, 10'd241, 10'd225, 10'd224};
    logic e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      set_lc(t[i]);
      chk("fan_run", {1'b0, e[i], 1'b0}, fan_run);
    end
  endtask
  task automatic t_failsafe();
    wr(8'h79, 8'h0A);
    set_lc(10'd200);
    wr(8'h6B, 8'h32);
    wr(8'h6D, 8'h46);
    out_cfg <= 1'b1;
    tick(2);
    chk("fs_at_limit", 3'b000, fsafe);
    set_lc(10'd201);
    chk("fs_over", 3'b010, fsafe);
    chk("pwm_full", {8'hFF, 8'hFF, 8'hFF}, {pwm1, pwm2, pwm3});
    chk("pin_drive", {1'b1, 1'b0, 1'b1}, {pin_oe, pin_o, irq});
    set_lc(10'd177);
    chk("fs_hold", 3'b010, fsafe);
    set_lc(10'd175);
    chk("fs_release", 3'b000, fsafe);
    chk("pwm_back", {8'h30, 8'h31, 8'h32}, {pwm1, pwm2, pwm3});
    rd("status_local", 8'h78, 8'h02);
    tick(2);
    chk("irq_cleared", 0, irq);
    @(posedge ref_clk);
    ext_low <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ext_low <= 1'b0;
    tick(2);
    chk("irq_pin", 1, irq);
    rd("status_pin", 8'h78, 8'h08);
    @(posedge ref_clk);
    raw_r1 <= 10'd401;
    tick(4);
    chk("fs_remote1", 3'b001, fsafe);
    chk("irq_masked", 0, irq);
    rd("status_r1", 8'h78, 8'h01);
    wr(8'h6C, 8'h80);
    @(posedge ref_clk);
    raw_r1 <= 10'd200;
    raw_r2 <= 10'd1023;
    tick(4);
    chk("fs_disabled", 3'b000, fsafe);
    @(posedge ref_clk);
    raw_r2 <= 10'd200;
  endtask
  task automatic t_offset();
    wr(8'h70, 8'hF6);
    wr(8'h71, 8'h05);
    wr(8'h72, 8'h80);
    @(posedge ref_clk);
    raw_r2 <= 10'd100;
    set_lc(10'd150);
    chk("corr_r1", 10'd180, c_r1);
    chk("corr_lc", 10'd160, c_lc);
    chk("corr_r2", 10'd0, c_r2);
    set_lc(10'd195);
    chk("fs_offset", 3'b010, fsafe);
    set_lc(10'd150);
    chk("fs_offset_rel", 3'b000, fsafe);
  endtask
  task automatic t_lock();
    do_reset();
    lock <= 1'b1;
    for (int i = 0; i < 9; i++) wr(ri[i], (i == 5) ? 8'h01 : 8'h55);
    for (int i = 0; i < 9; i++) rd("locked", ri[i], rv[i]);
    chk("locked_test", 0, test_en);
    lock <= 1'b0;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {cyc, stb, we, lock, out_cfg, ext_low} = '0;
    adr = '0;
    wdat = '0;
    sel = '0;
    {raw_r1, raw_lc, raw_r2} = {10'd200, 10'd200, 10'd200};
    {st_r1, st_lc, st_r2} = {8'd60, 8'd60, 8'd60};
    {ad1, ad2, ad3} = {8'h30, 8'h31, 8'h32};
    bad_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    do_reset();
    t_reset();
    t_regs();
    t_fan();
    t_failsafe();
    t_offset();
    t_lock();
    stop_test();
  end
endmodule // tb_top
